/* design/bit_sync.sv */
// two-stage synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level; bits are not kept coherent with each other
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk, // sampling clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] d, // asynchronous inputs
	output logic [WIDTH-1:0] q // synchronised outputs
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

`default_nettype wire

/* design/switch_cfg_pkg.sv */
// constants shared by the switch input configuration block
// assumes a 20 MHz core clock and a 24-bit command frame from the host
package switch_cfg_pkg;

	// ----------------------------------------------------------------
	// input counts and frame layout
	// ----------------------------------------------------------------
	localparam int PROG_INPUTS = 8;
	localparam int GROUND_INPUTS = 14;
	localparam int ALL_INPUTS = 22;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 16;
	localparam int PROG_DATA_MSB = 7;
	localparam int GND_DATA_MSB = 13;
	localparam int GND_FIELD_LSB = 8;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WAKE_PROG = 8'h02;
	localparam logic [7:0] CMD_WAKE_GND = 8'h03;
	localparam logic [7:0] CMD_LEVEL_PROG = 8'h04;
	localparam logic [7:0] CMD_LEVEL_GND = 8'h05;
	localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
	localparam logic [7:0] CMD_TIMER_GND = 8'h08;
	localparam logic [7:0] CMD_HIZ_PROG = 8'h09;
	localparam logic [7:0] CMD_HIZ_GND = 8'h0a;
	localparam logic [7:0] CMD_RESET = 8'h7f;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [21:0] WAKE_RESET = 22'h3fffff;
	localparam logic [21:0] LEVEL_RESET = 22'h3fffff;
	localparam logic [21:0] TIMER_RESET = 22'h3fffff;
	localparam logic [21:0] HIZ_RESET = 22'h3fffff;
	localparam logic [2:0] SPI_SYNC_RESET = 3'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_HZ = 20000000;
	localparam int TICK_TIME_US = 1000;
	localparam int WET_TIME_MS = 20;
	localparam int TICK_CYCLES = (CORE_CLK_HZ / 1000000) * TICK_TIME_US;
	localparam int WET_TICKS = (WET_TIME_MS * 1000) / TICK_TIME_US;
	localparam int ARM_CYCLES = 3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FRAME_IDLE = 2'b01,
		FRAME_SHIFT = 2'b10
	} frame_state_t;

endpackage

/* design/switch_input_config_regs.sv */
// per-input configuration registers loaded by 24-bit serial command words
// assumes mode-0 serial host, comparator outputs and sleep flag from outside
//
// How it works
// R1 - wake enable decides if an input may wake or pull interrupt low
// R2 - enable bit zero: input changes neither interrupt nor wake
// R3 - enable bit one: input change raises interrupt and wakes device; intN falls only when awake, wakeRequest only in sleep
// R4 - codes 02/03 load wake enables from bits 7..0 or 13..0
// R5 - level bit zero selects the low 2.0 mA wetting current
// R6 - level bit one selects the high 16 mA wetting current
// R7 - codes 04/05 load current level bits, programmable or ground half
// R8 - each input has its own 20 ms timer started by threshold crossing
// R9 - expired enabled timer drops that input from 16 mA to 2.0 mA
// R10 - disabled timer keeps 16 mA flowing with no reduction
// R11 - timer enable bit zero disables, one enables that input's timer
// R12 - codes 07/08 load timer enable bits, programmable or ground half
// R13 - high impedance bit one floats input, overriding current level
// R14 - comparator keeps sampling while input is high impedance
// R15 - codes 09/0a load high impedance bits, programmable or ground half
// R16 - registers accept updates at any time in normal mode
// R17 - only complete frames of exactly 24 bits are decoded
// R18 - reset: all wake, 16 mA, timers on, all high impedance
// R19 - chip select rise releases interrupt unless a switch closed meanwhile
// R20 - unknown command codes leave these registers unchanged
// R21 - addressed group loads all its bits at once at frame end
`timescale 1ns/10ps
`default_nettype none

module switch_input_config_regs #(
	parameter int TICK_CYCLES = switch_cfg_pkg::TICK_CYCLES,
	parameter int WET_TICKS = switch_cfg_pkg::WET_TICKS
) (
	input wire logic core_clk, // core clock
	input wire logic resetn, // power-on reset, active low
	input wire logic sclkPin, // serial clock from host
	input wire logic csnPin, // chip select, active low
	input wire logic mosiPin, // serial data from host
	input wire logic [21:0] switchClosed, // comparator says contact closed
	input wire logic sleepMode, // device is in sleep mode
	output logic intN, // interrupt to host, active low
	output logic wakeRequest, // one-cycle wake pulse while sleeping
	output logic [21:0] wakeEnable, // wake/interrupt enables
	output logic [21:0] sourceHigh, // drive 16 mA wetting current
	output logic [21:0] sourceLow, // drive 2.0 mA sustain current
	output logic [21:0] highZ // input node floated
);

	localparam int N = switch_cfg_pkg::ALL_INPUTS;
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int WET_W = $clog2(WET_TICKS + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [1:0] ARM_LAST = 2'(switch_cfg_pkg::ARM_CYCLES - 1);

	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	logic [2:0] spiSync;
	logic [N-1:0] swSync;
	logic sclkS;
	logic csnS;
	logic mosiS;

	bit_sync #(
		.WIDTH(3),
		.RESET_VAL(switch_cfg_pkg::SPI_SYNC_RESET)
	) spiSyncU (
		.clk(core_clk),
		.resetn(resetn),
		.d({sclkPin, csnPin, mosiPin}),
		.q(spiSync)
	);

	// comparators are sampled regardless of the high impedance setting
	bit_sync #(
		.WIDTH(N),
		.RESET_VAL('0)
	) swSyncU ( // R14
		.clk(core_clk),
		.resetn(resetn),
		.d(switchClosed),
		.q(swSync)
	);

	assign sclkS = spiSync[2];
	assign csnS = spiSync[1];
	assign mosiS = spiSync[0];

	// ----------------------------------------------------------------
	// serial frame capture
	// ----------------------------------------------------------------
	switch_cfg_pkg::frame_state_t state_r;
	logic sclkPrev_r;
	logic csnPrev_r;
	logic [23:0] shift_r;
	logic [4:0] bitCount_r;
	logic sclkRise;
	logic csnFall;
	logic csnRise;
	logic frameDone;
	logic [7:0] cmdCode;

	assign sclkRise = sclkS & ~sclkPrev_r;
	assign csnFall = csnPrev_r & ~csnS;
	assign csnRise = ~csnPrev_r & csnS;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclkPrev_r <= 1'b0;
			csnPrev_r <= 1'b1;
		end
		else
		begin
			sclkPrev_r <= sclkS;
			csnPrev_r <= csnS;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= switch_cfg_pkg::FRAME_IDLE;
			shift_r <= 24'h000000;
			bitCount_r <= 5'h00;
		end
		else
		begin
			case (state_r)
				switch_cfg_pkg::FRAME_IDLE:
				begin
					if (csnFall)
					begin
						state_r <= switch_cfg_pkg::FRAME_SHIFT;
						bitCount_r <= 5'h00;
					end
				end
				switch_cfg_pkg::FRAME_SHIFT:
				begin
					if (csnRise)
						state_r <= switch_cfg_pkg::FRAME_IDLE;
					else if (sclkRise)
					begin
						shift_r <= {shift_r[22:0], mosiS};
						// saturate so overlong frames never wrap back to 24
						if (bitCount_r != 5'h1f)
							bitCount_r <= bitCount_r + 5'h01; // R17
					end
				end
				default:
					state_r <= switch_cfg_pkg::FRAME_IDLE;
			endcase
		end
	end

	// decode only after chip select closes a full frame, in normal mode
	assign frameDone = (state_r == switch_cfg_pkg::FRAME_SHIFT) && csnRise
		&& (bitCount_r == switch_cfg_pkg::FRAME_BITS) && !sleepMode; // R16 R17
	assign cmdCode = shift_r[switch_cfg_pkg::CMD_MSB:switch_cfg_pkg::CMD_LSB];

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [N-1:0] wake_r;
	logic [N-1:0] level_r;
	logic [N-1:0] timerEn_r;
	logic [N-1:0] hiz_r;

	// whole half-group replaced at once; foreign codes keep the value
	function automatic logic [21:0] nextGroup(
		input logic [21:0] cur,
		input logic [21:0] resetVal,
		input logic [7:0] code,
		input logic [23:0] frame,
		input logic [7:0] progCode,
		input logic [7:0] gndCode
	);
		logic [21:0] result;
		result = cur;
		if (code == switch_cfg_pkg::CMD_RESET)
			result = resetVal; // R18
		else if (code == progCode)
			result[switch_cfg_pkg::PROG_DATA_MSB:0] = frame[switch_cfg_pkg::PROG_DATA_MSB:0]; // R21
		else if (code == gndCode)
			result[21:switch_cfg_pkg::GND_FIELD_LSB] = frame[switch_cfg_pkg::GND_DATA_MSB:0]; // R21
		return result; // R20
	endfunction

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			wake_r <= switch_cfg_pkg::WAKE_RESET; // R18
		else if (frameDone)
			wake_r <= nextGroup(wake_r, switch_cfg_pkg::WAKE_RESET, cmdCode, shift_r,
				switch_cfg_pkg::CMD_WAKE_PROG, switch_cfg_pkg::CMD_WAKE_GND); // R4
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			level_r <= switch_cfg_pkg::LEVEL_RESET; // R18
		else if (frameDone)
			level_r <= nextGroup(level_r, switch_cfg_pkg::LEVEL_RESET, cmdCode, shift_r,
				switch_cfg_pkg::CMD_LEVEL_PROG, switch_cfg_pkg::CMD_LEVEL_GND); // R7
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			timerEn_r <= switch_cfg_pkg::TIMER_RESET; // R18
		else if (frameDone)
			timerEn_r <= nextGroup(timerEn_r, switch_cfg_pkg::TIMER_RESET, cmdCode, shift_r,
				switch_cfg_pkg::CMD_TIMER_PROG, switch_cfg_pkg::CMD_TIMER_GND); // R11 R12
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			hiz_r <= switch_cfg_pkg::HIZ_RESET; // R18
		else if (frameDone)
			hiz_r <= nextGroup(hiz_r, switch_cfg_pkg::HIZ_RESET, cmdCode, shift_r,
				switch_cfg_pkg::CMD_HIZ_PROG, switch_cfg_pkg::CMD_HIZ_GND); // R15
	end

	// ----------------------------------------------------------------
	// change detection
	// ----------------------------------------------------------------
	logic [N-1:0] swPrev_r;
	logic [1:0] armCount_r;
	logic armed_r;
	logic [N-1:0] change;
	logic enabledChange;
	logic enabledClose;

	// ignore the settling of the synchroniser after reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			armCount_r <= 2'h0;
			armed_r <= 1'b0;
		end
		else if (!armed_r)
		begin
			if (armCount_r == ARM_LAST)
				armed_r <= 1'b1;
			else
				armCount_r <= armCount_r + 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			swPrev_r <= '0;
		else
			swPrev_r <= swSync;
	end

	assign change = armed_r ? (swSync ^ swPrev_r) : '0;
	assign enabledChange = |(change & wake_r); // R1 R2 R3
	assign enabledClose = |(change & swSync & wake_r);

	// ----------------------------------------------------------------
	// interrupt and wake
	// ----------------------------------------------------------------
	logic closedDuringCs_r;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			closedDuringCs_r <= 1'b0;
		else if (!csnS && enabledClose)
			closedDuringCs_r <= 1'b1;
		else if (csnFall)
			closedDuringCs_r <= 1'b0;
	end

	// a new change wins over a release in the same cycle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			intN <= 1'b1;
		else if (!sleepMode && enabledChange)
			intN <= 1'b0; // R3
		else if (csnRise && !closedDuringCs_r)
			intN <= 1'b1; // R19
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			wakeRequest <= 1'b0;
		else
			wakeRequest <= sleepMode && enabledChange; // R1 R3
	end

	// ----------------------------------------------------------------
	// wetting timers
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] tickCount_r;
	logic tick_r;
	logic [N-1:0] expired;

	// one shared divider keeps each timer down to a few bits
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tickCount_r <= '0;
			tick_r <= 1'b0;
		end
		else if (tickCount_r == TICK_LAST)
		begin
			tickCount_r <= '0;
			tick_r <= 1'b1;
		end
		else
		begin
			tickCount_r <= tickCount_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : perInput
			wetting_timer #(
				.TICKS(WET_TICKS),
				.CNT_W(WET_W)
			) timerU ( // R8
				.clk(core_clk),
				.resetn(resetn),
				.tick(tick_r),
				.restart(change[gi]),
				.expired(expired[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// current source drive
	// ----------------------------------------------------------------
	logic [N-1:0] wantHigh;

	// high current where the level bit is set, unless the enabled timer has run out
	assign wantHigh = level_r & ~(timerEn_r & expired); // R6 R9 R10

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sourceHigh <= '0;
			sourceLow <= '0;
			highZ <= '1;
			wakeEnable <= switch_cfg_pkg::WAKE_RESET;
		end
		else
		begin
			sourceHigh <= wantHigh & ~hiz_r; // R13
			sourceLow <= ~wantHigh & ~hiz_r; // R5 R9 R13
			highZ <= hiz_r; // R13
			wakeEnable <= wake_r;
		end
	end

endmodule

`default_nettype wire

/* design/wetting_timer.sv */
// per-input wetting interval timer counting shared ticks
// assumes tick is a one-cycle enable from a common divider
`timescale 1ns/10ps
`default_nettype none

module wetting_timer #(
	parameter int TICKS = 20,
	parameter int CNT_W = 5
) (
	input wire logic clk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic tick, // one-cycle timebase pulse
	input wire logic restart, // threshold crossing, restarts the interval
	output logic expired // interval elapsed since last crossing
);

	localparam logic [CNT_W-1:0] LAST = CNT_W'(TICKS - 1);

	logic [CNT_W-1:0] count_r;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_r <= '0;
			expired <= 1'b0;
		end
		else if (restart)
		begin
			count_r <= '0;
			expired <= 1'b0;
		end
		else if (tick && !expired)
		begin
			if (count_r == LAST)
				expired <= 1'b1;
			else
				count_r <= count_r + 1'b1;
		end
	end

endmodule

`default_nettype wire

/* test/spi_host_model.sv */
// host side of the serial link: sends command frames, mode 0, MSB first
// assumes the bench core clock paces it; link clock is 400 ns and idles low
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
	input wire logic clk, // bench core clock
	output logic sclk, // serial clock, idle low
	output logic csn, // chip select, active low
	output logic mosi // serial data
);
	initial
	begin
		sclk = 1'b0;
		csn = 1'b1;
		mosi = 1'b0;
	end

	// bit counts other than 24 only where a refusal is wanted
	task automatic send(input logic [23:0] word, input int nBits);
		logic b;
		b = 1'b0;
		@(negedge clk);
		csn = 1'b0;
		for (int i = 0; i < nBits; i++)
		begin
			b = (i < 24) ? word[23 - i] : 1'b0;
			mosi = b;
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		csn = 1'b1;
		// released line shows the inverse so a stale bit cannot pass
		mosi = ~b;
		repeat (10) @(negedge clk);
	endtask
endmodule

`default_nettype wire

/* test/switch_cfg_properties.sv */
// checker for the switch input configuration block, bound to its top module
// assumes a single core clock domain and the active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none

module switch_cfg_properties #(
	parameter int TICK_CYCLES = 20000,
	parameter int WET_TICKS = 20
) (
	input wire logic core_clk, // core clock
	input wire logic resetn, // reset, active low
	input wire logic sclkPin, // serial clock
	input wire logic csnPin, // chip select, active low
	input wire logic mosiPin, // serial data
	input wire logic [21:0] switchClosed, // comparator states
	input wire logic sleepMode, // sleep flag
	input wire logic intN, // interrupt, active low
	input wire logic wakeRequest, // wake pulse
	input wire logic [21:0] wakeEnable, // wake enables
	input wire logic [21:0] sourceHigh, // 16 mA drive
	input wire logic [21:0] sourceLow, // 2.0 mA drive
	input wire logic [21:0] highZ // floated inputs
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_RESET_VALUES: assert property ($rose(resetn) |-> highZ == 22'h3fffff && wakeEnable == 22'h3fffff
		&& sourceHigh == 22'h0 && intN)
		else $error("outputs not at reset values after reset release");
	AST_HIZ_FLOATS: assert property ((highZ & (sourceHigh | sourceLow)) == 22'h0)
		else $error("floated input still driven");
	AST_ONE_LEVEL: assert property ((sourceHigh ^ sourceLow) == ~highZ)
		else $error("driven input lacks exactly one current level");
	// a frame must have ended before wakeEnable or highZ moves
	AST_CFG_AFTER_FRAME: assert property (($changed(wakeEnable) || $changed(highZ))
		|-> csnPin && $past(csnPin, 2))
		else $error("configuration changed without a completed frame");
	AST_INT_RELEASE: assert property ($rose(intN) |-> csnPin && $past(csnPin))
		else $error("interrupt released without chip select rise");
	AST_INT_AWAKE: assert property ($fell(intN) |-> !$past(sleepMode))
		else $error("interrupt raised while sleeping");
	AST_INT_NEEDS_ENABLE: assert property ($fell(intN)
		|-> (wakeEnable | $past(wakeEnable) | $past(wakeEnable, 2)) != 22'h0)
		else $error("interrupt raised with every input disabled");
	// an enabled input that moves while awake must pull the interrupt low or wake
	AST_INT_ON_CHANGE: assert property (!sleepMode && ((switchClosed ^ $past(switchClosed)) & wakeEnable) != 22'h0
		|-> ##[1:4] (!intN || wakeRequest))
		else $error("enabled input change raised no interrupt");
	AST_WAKE_IN_SLEEP: assert property (wakeRequest |-> $past(sleepMode))
		else $error("wake request outside sleep");
	AST_WAKE_PULSE: assert property (wakeRequest |=> !wakeRequest)
		else $error("wake request longer than one cycle");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	COV_INT: cover property ($fell(intN));
	COV_WAKE: cover property (wakeRequest);
	COV_DROP: cover property ($fell(sourceHigh[0]) && !highZ[0]);
endmodule

bind switch_input_config_regs switch_cfg_properties #(.TICK_CYCLES(TICK_CYCLES), .WET_TICKS(WET_TICKS)) chk_u (
	.core_clk(core_clk), .resetn(resetn), .sclkPin(sclkPin), .csnPin(csnPin), .mosiPin(mosiPin),
	.switchClosed(switchClosed), .sleepMode(sleepMode), .intN(intN), .wakeRequest(wakeRequest),
	.wakeEnable(wakeEnable), .sourceHigh(sourceHigh), .sourceLow(sourceLow), .highZ(highZ));

`default_nettype wire

/* test/test_switch_input_config_regs.sv */
// self-checking bench for the switch input configuration block
// assumes the host model on the link and short timer parameters
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_switch_input_config_regs;
	localparam int TICKS_SHORT = 10;
	localparam int WET_SHORT = 4;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [21:0] switchClosed = 22'h0;
	logic sleepMode = 1'b0;
	logic sclkPin;
	logic csnPin;
	logic mosiPin;
	logic intN;
	logic wakeRequest;
	logic [21:0] wakeEnable;
	logic [21:0] sourceHigh;
	logic [21:0] sourceLow;
	logic [21:0] highZ;
	logic [21:0] expWake = 22'h3fffff;
	logic [21:0] expLvl = 22'h3fffff;
	logic [21:0] expTmr = 22'h3fffff;
	logic [21:0] expHiz = 22'h3fffff;
	int fails = 0;
	int totalChecks = 0;
	int cycles = 0;

	always #25 core_clk = ~core_clk;

	switch_input_config_regs #(.TICK_CYCLES(TICKS_SHORT), .WET_TICKS(WET_SHORT)) dut_u (
		.core_clk(core_clk), .resetn(resetn), .sclkPin(sclkPin), .csnPin(csnPin), .mosiPin(mosiPin),
		.switchClosed(switchClosed), .sleepMode(sleepMode), .intN(intN), .wakeRequest(wakeRequest),
		.wakeEnable(wakeEnable), .sourceHigh(sourceHigh), .sourceLow(sourceLow), .highZ(highZ));

	spi_host_model host_u (.clk(core_clk), .sclk(sclkPin), .csn(csnPin), .mosi(mosiPin));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			stop_test();
		end
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// every untouched timer has long expired when this runs, except right after reset while every input still floats
	task automatic check_outputs();
		`CHK(wakeEnable, expWake)
		`CHK(highZ, expHiz)
		`CHK(sourceHigh, expLvl & ~expTmr & ~expHiz)
		`CHK(sourceLow, ~(expLvl & ~expTmr) & ~expHiz)
	endtask

	task automatic write_cmd(input logic [23:0] word);
		host_u.send(word, 24);
		case (word[23:16])
			8'h02: expWake[7:0] = word[7:0];
			8'h03: expWake[21:8] = word[13:0];
			8'h04: expLvl[7:0] = word[7:0];
			8'h05: expLvl[21:8] = word[13:0];
			8'h07: expTmr[7:0] = word[7:0];
			8'h08: expTmr[21:8] = word[13:0];
			8'h09: expHiz[7:0] = word[7:0];
			8'h0a: expHiz[21:8] = word[13:0];
			8'h7f:
			begin
				expWake = 22'h3fffff;
				expLvl = 22'h3fffff;
				expTmr = 22'h3fffff;
				expHiz = 22'h3fffff;
			end
			default: ;
		endcase
		check_outputs();
	endtask

	task automatic count_wake(output int n);
		n = 0;
		repeat (12)
		begin
			@(negedge core_clk);
			if (wakeRequest === 1'b1)
				n++;
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		check_outputs();
		`CHK(intN, 1'b1)
	endtask

	// don't-care bits set high so the other half must stay put
	task automatic test_codes();
		logic [23:0] w [8];
		w = '{24'h09ff00, 24'h0ac000, 24'h04ffa5, 24'h05eaaa, 24'h07ff0f, 24'h08d555, 24'h02ffa5, 24'h03fc3c};
		foreach (w[i])
			write_cmd(w[i]);
	endtask

	task automatic test_refused();
		logic [23:0] w [5];
		int n [5];
		w = '{24'h01ffff, 24'h06ffff, 24'h7effff, 24'h09ffff, 24'h0affff};
		n = '{24, 24, 24, 23, 25};
		foreach (w[i])
		begin
			host_u.send(w[i], n[i]);
			check_outputs();
		end
	endtask

	task automatic test_timer_int();
		switchClosed[0] = 1'b1;
		wait_cyc(8);
		`CHK(sourceHigh[0], 1'b1)
		`CHK(intN, 1'b0)
		wait_cyc(60);
		`CHK(sourceHigh[0], 1'b0)
		`CHK(sourceLow[0], 1'b1)
		host_u.send(24'h0, 24);
		`CHK(intN, 1'b1)
		fork
			host_u.send(24'h0, 24);
			begin
				wait_cyc(40);
				switchClosed[2] = 1'b1;
			end
		join
		`CHK(intN, 1'b0)
		host_u.send(24'h0, 24);
		`CHK(intN, 1'b1)
		switchClosed[1] = 1'b1;
		wait_cyc(10);
		`CHK(intN, 1'b1)
	endtask

	task automatic test_sleep();
		int n;
		sleepMode = 1'b1;
		wait_cyc(2);
		switchClosed[0] = 1'b0;
		count_wake(n);
		`CHK(n, 1)
		`CHK(intN, 1'b1)
		switchClosed[1] = 1'b0;
		count_wake(n);
		`CHK(n, 0)
		host_u.send(24'h0a0000, 24);
		check_outputs();
		sleepMode = 1'b0;
	endtask

	initial
	begin
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		wait_cyc(12);
		test_reset();
		test_codes();
		test_refused();
		test_timer_int();
		test_sleep();
		write_cmd(24'h7f0000);
		stop_test();
	end
endmodule

`default_nettype wire
